//--- verilog/dlldqs_top.sv
// Delay-locked loop servo with strobe delay logic for one I/O bank
`timescale 1ns/1ps
// Notes on behaviour
// - The loop searches for a 9-bit chain setting whose delay equals one reference period.
// - One loop per bank serves reference clocks from 600 MHz to 1.3 GHz.
// - The reference clock is the bank PLL output, which is core_clk here.
// - The reference is divided by eight into launch and measure pulses one cycle apart.
// - Launch passes through the chain and its delayed copy is compared with measure.
// - A 9-bit up/down counter steps by the comparison until the pulses align.
// - On lock the counter value is forwarded to the strobe delay logic.
// - Strobe logic holds post-amble register, delay chain, FIFO control and rank switch.
// - The strobe chain delay is adjustable during calibration for best capture margin.
// - Tracking keeps the applied strobe delay constant over temperature and voltage drift.
// - Up to four calibrated settings sit in shadow registers and are switched between.
// - Controller and bank sequencer talk over a dedicated memory-mapped port per bank.
// - Sequencer components sit on the memory-mapped bus for control and observation.
module dlldqs_top
  import dlldqs_pkg::*;
#(
  parameter int DIV_RATIO = `DLLDQS_DIV_RATIO
) (
  // Clock and reset (bank PLL output)
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Calibration controller port
  input  wire logic              cal_start,
  input  wire logic              shadow_we,
  input  wire dlldqs_rank_t      shadow_idx,
  input  wire dlldqs_code_t      shadow_data,
  input  wire dlldqs_rank_t      rank_sel,
  // Delay chain feedback (pin side, asynchronous)
  input  wire logic              chain_late,
  // Strobe pin side
  input  wire logic              strobe_in,
  input  wire logic              postamble_en,
  // Loop outputs
  output logic                   launch_pulse,
  output logic                   measure_pulse,
  output dlldqs_code_t           dll_code,
  output logic                   dll_locked,
  output dlldqs_code_t           dll_setting,
  output logic                   busy,
  // Strobe outputs
  output logic                   strobe_gated,
  output logic                   fifo_wr_en,
  output dlldqs_code_t           chain_setting
);

  // ********************************
  // Reference band and elaboration checks
  // ********************************
  // One loop per bank serves the whole band; the slowest clock asks the
  // most taps of the chain, so the counter range must cover that end
  localparam int FREQ_MIN_MHZ = `DLLDQS_FREQ_MIN_MHZ;
  localparam int FREQ_MAX_MHZ = `DLLDQS_FREQ_MAX_MHZ;

  // Refuse settings the divider or rank index cannot serve, and an empty reference band
  initial begin
    if (DIV_RATIO != 8)
      $error("DIV_RATIO must be 8");
    if (DIV_RATIO != (1 << `DLLDQS_DIV_W))
      $error("divider width does not match the ratio");
    if (`DLLDQS_RANKS > (1 << `DLLDQS_RANK_W))
      $error("rank index too narrow for the shadow count");
    if (FREQ_MIN_MHZ < 1 || FREQ_MIN_MHZ > FREQ_MAX_MHZ)
      $error("reference band is empty");
  end

  // ********************************
  // Divider and pulse generation
  // ********************************
  // Free-running divider; every loop action is tied to one phase of it,
  // so the far side and the servo never race each other
  logic [`DLLDQS_DIV_W-1:0] div_cnt;
  logic                     compare_slot;

  // Divide by eight; launch at phase 0, measure at phase 1.
  // Phase map of one divided period, by div_cnt during the cycle:
  //   1: launch_pulse high, the far side launches into the chain
  //   2: measure_pulse high, one reference cycle after launch
  //   2..3: the detector answer appears on chain_late
  //   3..5: the answer crosses the two synchroniser stages
  //   6: compare slot, the counter takes at most one step
  //   0: the new setting shows on dll_code before the next launch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // Pulses are registered so the far side sees clean one-cycle strobes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      launch_pulse  <= 1'b0;
      measure_pulse <= 1'b0;
    end else begin
      launch_pulse  <= (div_cnt == 3'h0);
      measure_pulse <= (div_cnt == 3'h1);
    end
  end

  // One compare per divided period, late enough for the synchroniser.
  // An earlier slot would act on the answer for the previous setting
  // and could step twice for one measurement.
  assign compare_slot = (div_cnt == 3'h6);

  // ********************************
  // Phase detector input synchroniser
  // ********************************
  // The detector answer comes from the analogue chain and has no
  // timing relation to core_clk, so it crosses two flops first
  logic late_meta;
  logic late_sync;

  // Delayed launch vs measure comparison result from the chain.
  // Only late_sync feeds logic; late_meta may still be settling.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      late_meta <= 1'b0;
      late_sync <= 1'b0;
    end else begin
      late_meta <= chain_late;
      late_sync <= late_meta;
    end
  end

  // ********************************
  // Strobe pin synchronisers
  // ********************************
  // The strobe and its enable arrive from pins and cross two flops each;
  // a skew of one cycle between them only trims one gated cycle
  logic strobe_meta;
  logic strobe_sync;
  logic pam_meta;
  logic pam_sync;

  // Strobe pin, two stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe_meta <= 1'b0;
      strobe_sync <= 1'b0;
    end else begin
      strobe_meta <= strobe_in;
      strobe_sync <= strobe_meta;
    end
  end

  // Post-amble enable pin, two stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pam_meta <= 1'b0;
      pam_sync <= 1'b0;
    end else begin
      pam_meta <= postamble_en;
      pam_sync <= pam_meta;
    end
  end

  // ********************************
  // Servo state machine and counter
  // ********************************
  // The counter runs whenever a search has been started, so a locked
  // loop keeps following slow drift of the chain
  dlldqs_state_t state;
  dlldqs_code_t  code;
  logic          last_dir;
  logic          have_dir;
  logic          reversal;
  logic          step_up;
  logic          at_top;
  logic          at_bot;

  // Late delayed launch means too much delay: step down.
  // A reversal is a change of direction between two compare slots.
  assign step_up  = ~late_sync;
  assign reversal = have_dir && (last_dir != step_up);
  assign at_top   = (code == 9'h1FF);
  assign at_bot   = (code == 9'h000);

  // Search starts on cal_start; a reversal at a compare slot means lock.
  // A cal_start while searching is ignored; one while locked relocks.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= DLLDQS_IDLE;
    end else begin
      unique case (state)
        DLLDQS_IDLE: begin
          if (cal_start)
            state <= DLLDQS_SEARCH;
        end
        DLLDQS_SEARCH: begin
          if (compare_slot && reversal)
            state <= DLLDQS_LOCKED;
        end
        DLLDQS_LOCKED: begin
          if (cal_start)
            state <= DLLDQS_SEARCH;
        end
        default: state <= DLLDQS_IDLE;
      endcase
    end
  end

  // Up/down counter, one step per comparison, saturating.
  // Saturation keeps a chain that cannot reach one period from wrapping
  // round to the far end of the range; the loop then never locks and
  // busy stays high, which the controller can see.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      code <= `DLLDQS_CODE_MID;
    end else if (state != DLLDQS_IDLE && compare_slot) begin
      if (step_up && !at_top)
        code <= code + 9'h001;
      else if (!step_up && !at_bot)
        code <= code - 9'h001;
    end
  end

  // Direction history for reversal detection.
  // Cleared on each new search so an old direction cannot fake a lock.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_dir <= 1'b0;
      have_dir <= 1'b0;
    end else if (state == DLLDQS_IDLE || (cal_start && state == DLLDQS_LOCKED)) begin
      have_dir <= 1'b0;
    end else if (compare_slot) begin
      last_dir <= step_up;
      have_dir <= 1'b1;
    end
  end

  // Lock flag follows the state one edge later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dll_locked <= 1'b0;
    end else begin
      dll_locked <= (state == DLLDQS_LOCKED);
    end
  end

  // Forwarded setting follows the counter while locked
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dll_setting <= `DLLDQS_CODE_MID;
    end else if (state == DLLDQS_LOCKED) begin
      dll_setting <= code;
    end
  end

  // Registered copy of the counter for observation
  always_ff @(posedge core_clk) begin
    if (rst) begin
      dll_code <= `DLLDQS_CODE_MID;
    end else begin
      dll_code <= code;
    end
  end

  // Busy while a search is running
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state == DLLDQS_SEARCH);
    end
  end

  // ********************************
  // Strobe delay logic
  // ********************************
  // Tracking is applied only while locked, so a search in progress
  // never disturbs the strobe chain with a half-found setting
  dlldqs_strobe_delay #(
    .RANKS   (`DLLDQS_RANKS),
    .TRACK_W (`DLLDQS_TRACK_W)
  ) u_strobe (
    .core_clk      (core_clk),
    .rst           (rst),
    .ref_valid     (dll_locked),
    .ref_code      (dll_setting),
    .shadow_we     (shadow_we),
    .shadow_idx    (shadow_idx),
    .shadow_data   (shadow_data),
    .rank_sel      (rank_sel),
    .strobe_in     (strobe_sync),
    .postamble_en  (pam_sync),
    .strobe_gated  (strobe_gated),
    .fifo_wr_en    (fifo_wr_en),
    .chain_setting (chain_setting)
  );

endmodule

//--- include/dlldqs_defines.svh
// Constants for the delay-locked loop and strobe delay block
`ifndef DLLDQS_DEFINES_SVH
`define DLLDQS_DEFINES_SVH
`define DLLDQS_CODE_W        9
`define DLLDQS_CODE_MID      9'h100
`define DLLDQS_DIV_RATIO     8
`define DLLDQS_DIV_W         3
`define DLLDQS_RANKS         4
`define DLLDQS_RANK_W        2
`define DLLDQS_FREQ_MIN_MHZ  600
`define DLLDQS_FREQ_MAX_MHZ  1300
`define DLLDQS_TRACK_W       6
`endif

//--- include/dlldqs_pkg.sv
// Types for the delay-locked loop and strobe delay block
`include "dlldqs_defines.svh"
package dlldqs_pkg;
  typedef logic [`DLLDQS_CODE_W-1:0] dlldqs_code_t;
  typedef logic [`DLLDQS_RANK_W-1:0] dlldqs_rank_t;
  typedef enum logic [1:0] {
    DLLDQS_IDLE,
    DLLDQS_SEARCH,
    DLLDQS_LOCKED
  } dlldqs_state_t;
endpackage

//--- verilog/dlldqs_strobe_delay.sv
// Strobe delay logic: shadow settings, rank switch, drift tracking
`timescale 1ns/1ps
module dlldqs_strobe_delay
  import dlldqs_pkg::*;
#(
  parameter int RANKS   = `DLLDQS_RANKS,
  parameter int TRACK_W = `DLLDQS_TRACK_W
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // Loop reference setting
  input  wire logic              ref_valid,
  input  wire dlldqs_code_t      ref_code,
  // Shadow write port from calibration controller
  input  wire logic              shadow_we,
  input  wire dlldqs_rank_t      shadow_idx,
  input  wire dlldqs_code_t      shadow_data,
  // Rank select
  input  wire dlldqs_rank_t      rank_sel,
  // Post-amble and FIFO control
  input  wire logic              strobe_in,
  input  wire logic              postamble_en,
  // Outputs
  output logic                   strobe_gated,
  output logic                   fifo_wr_en,
  output dlldqs_code_t           chain_setting
);

  initial begin
    if (RANKS < 1 || RANKS > 4)
      $error("RANKS must be 1 to 4");
    if (TRACK_W < 2 || TRACK_W > 8)
      $error("TRACK_W out of range");
  end

  // ********************************
  // Shadow registers
  // ********************************
  dlldqs_code_t shadow [RANKS];
  dlldqs_code_t base_ref;
  logic [`DLLDQS_CODE_W:0] sum_wide;
  logic [`DLLDQS_CODE_W:0] track_diff;

  // Calibrated values per rank
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < RANKS; i++)
        shadow[i] <= '0;
    end else if (shadow_we && int'(shadow_idx) < RANKS) begin
      shadow[shadow_idx] <= shadow_data;
    end
  end

  // Reference captured when shadows are written, to track drift later
  always_ff @(posedge core_clk) begin
    if (rst) begin
      base_ref <= `DLLDQS_CODE_MID;
    end else if (shadow_we) begin
      base_ref <= ref_code;
    end
  end

  // ********************************
  // Tracking and chain setting
  // ********************************
  // Offset the shadow value by the difference of current and calibrated reference
  always_comb begin
    track_diff = {1'b0, ref_code} - {1'b0, base_ref};
    sum_wide   = {1'b0, shadow[int'(rank_sel) % RANKS]}
                 + (ref_valid ? track_diff : '0);
  end

  // Selected and tracked setting drives the chain on the next edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chain_setting <= '0;
    end else begin
      chain_setting <= sum_wide[`DLLDQS_CODE_W-1:0];
    end
  end

  // ********************************
  // Post-amble register and FIFO control
  // ********************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      strobe_gated <= 1'b0;
      fifo_wr_en   <= 1'b0;
    end else begin
      strobe_gated <= strobe_in & postamble_en;
      fifo_wr_en   <= strobe_in & postamble_en;
    end
  end

endmodule

//--- tb/dlldqs_chain_model.sv
// Delay chain and phase detector model standing on the far side of the loop
`timescale 1ns/1ps
// ****************
// Chain model
// ****************
module dlldqs_chain_model
  import dlldqs_pkg::*;
#(
  parameter int SLOW = 0
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // Pulses and setting from the loop
  input  wire logic         launch_pulse,
  input  wire logic         measure_pulse,
  input  wire dlldqs_code_t dll_code,
  // Setting worth one reference period
  input  wire dlldqs_code_t target,
  // Phase comparison result
  output logic              chain_late
);
  logic late_q;
  // Slow mode answers one cycle later, on the measure pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      late_q <= 1'h0;
    end else if (SLOW != 0 ? measure_pulse : launch_pulse) begin
      late_q <= (dll_code > target);
    end
  end
  assign chain_late = late_q;
endmodule

//--- tb/dlldqs_top_sva.sv
// Assertion checker for the loop and strobe delay top
`timescale 1ns/1ps
// ****************
// Checker
// ****************
module dlldqs_top_sva
  import dlldqs_pkg::*;
#(
  parameter int DIV_RATIO = 8
) (
  // Clock and reset
  input wire logic         core_clk,
  input wire logic         rst,
  // Controller and pin inputs
  input wire logic         cal_start,
  input wire logic         shadow_we,
  input wire dlldqs_rank_t shadow_idx,
  input wire dlldqs_code_t shadow_data,
  input wire dlldqs_rank_t rank_sel,
  input wire logic         strobe_in,
  input wire logic         postamble_en,
  // Design outputs
  input wire logic         launch_pulse,
  input wire logic         measure_pulse,
  input wire dlldqs_code_t dll_code,
  input wire logic         dll_locked,
  input wire dlldqs_code_t dll_setting,
  input wire logic         busy,
  input wire logic         strobe_gated,
  input wire logic         fifo_wr_en,
  input wire dlldqs_code_t chain_setting
);
  dlldqs_code_t shadow [4];
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Mirror of the shadow settings
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow <= '{default: 9'h000};
    end else if (shadow_we) begin
      shadow[shadow_idx] <= shadow_data;
    end
  end
  a_measure_lag: assert property (launch_pulse |=> measure_pulse && !launch_pulse)
    else $error("measure pulse not one cycle after launch");
  a_launch_period: assert property (launch_pulse |=> !launch_pulse [*7] ##1 launch_pulse)
    else $error("launch period wrong");
  a_code_step: assert property (busy && $past(busy) |->
    (dll_code - $past(dll_code)) inside {9'h000, 9'h001, 9'h1FF})
    else $error("counter moved more than one step");
  a_step_spacing: assert property ($changed(dll_code) && busy |=> $stable(dll_code) [*7])
    else $error("counter stepped twice in one period");
  a_busy_start: assert property (cal_start && !busy |-> ##2 busy)
    else $error("search did not start");
  a_lock_holds: assert property (dll_locked && !cal_start && !$past(cal_start) |=>
    dll_locked)
    else $error("lock dropped");
  a_busy_ends: assert property ($fell(busy) |-> ##[0:2] dll_locked)
    else $error("search ended without lock");
  a_setting_lock: assert property ($rose(dll_locked) |-> ##[0:2] dll_setting == dll_code)
    else $error("setting not forwarded at lock");
  a_rank_apply: assert property (!dll_locked && !$past(dll_locked) |->
    chain_setting == $past(shadow[rank_sel]))
    else $error("rank setting not applied");
  a_strobe_gate: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3) |->
    strobe_gated == $past(strobe_in && postamble_en, 3) && fifo_wr_en == strobe_gated)
    else $error("strobe gating wrong");
endmodule
bind dlldqs_top dlldqs_top_sva #(.DIV_RATIO(DIV_RATIO)) u_sva (.core_clk, .rst, .cal_start,
  .shadow_we, .shadow_idx, .shadow_data, .rank_sel, .strobe_in, .postamble_en, .launch_pulse,
  .measure_pulse, .dll_code, .dll_locked, .dll_setting, .busy, .strobe_gated, .fifo_wr_en,
  .chain_setting);

//--- tb/tb_dll_dqs_delay_calibration.sv
// Testbench for the loop and strobe delay top
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module tb_dll_dqs_delay_calibration;
  import dlldqs_pkg::*;
  typedef struct packed {
    dlldqs_rank_t rank;
    logic         stb;
    logic         pam;
    dlldqs_code_t exp_chain;
    logic         exp_gate;
  } dlldqs_row_t;
  localparam dlldqs_code_t SH [4] = '{9'h011, 9'h0A2, 9'h133, 9'h1FF};
  localparam dlldqs_row_t ROWS [5] = '{'{2'h0, 1'h1, 1'h1, 9'h011, 1'h1},
    '{2'h1, 1'h1, 1'h0, 9'h0A2, 1'h0}, '{2'h2, 1'h0, 1'h1, 9'h133, 1'h0},
    '{2'h3, 1'h1, 1'h1, 9'h1FF, 1'h1}, '{2'h0, 1'h0, 1'h0, 9'h011, 1'h0}};
  logic         core_clk, rst, cal_start, shadow_we, strobe_in, postamble_en, chain_late;
  logic         launch_pulse, measure_pulse, dll_locked, busy, strobe_gated, fifo_wr_en;
  dlldqs_rank_t shadow_idx, rank_sel;
  dlldqs_code_t shadow_data, dll_code, dll_setting, chain_setting, target;
  int           num_errors = 0;
  int           checked = 0;

  dlldqs_top #(.DIV_RATIO(8)) u_dut (.core_clk, .rst, .cal_start, .shadow_we, .shadow_idx,
    .shadow_data, .rank_sel, .chain_late, .strobe_in, .postamble_en, .launch_pulse,
    .measure_pulse, .dll_code, .dll_locked, .dll_setting, .busy, .strobe_gated, .fifo_wr_en,
    .chain_setting);
  dlldqs_chain_model #(.SLOW(0)) u_model (.core_clk, .rst, .launch_pulse, .measure_pulse,
    .dll_code, .target, .chain_late);

  // Clock, 4 ns period
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input dlldqs_code_t got, input dlldqs_code_t exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask
  // Within two steps, modulo the counter range
  function automatic logic near(input dlldqs_code_t a, input dlldqs_code_t b);
    dlldqs_code_t d;
    d = a - b;
    return (d <= 9'h002) || (d >= 9'h1FE);
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task do_reset;
    rst = 1'h1;
    step(2);
    rst = 1'h0;
    chk(dll_code, 9'h100);
    chk(dll_setting, 9'h100);
    chk(dll_locked, 9'h000);
    chk(busy, 9'h000);
    chk(chain_setting, 9'h000);
    $display("test reset done");
  endtask
  // Watchdog against a hung search
  initial begin
    repeat (3000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end
  // Main sequence
  initial begin
    {cal_start, shadow_we, strobe_in, postamble_en} = 4'h0;
    shadow_idx = 2'h0;
    shadow_data = 9'h000;
    rank_sel = 2'h0;
    target = 9'h0F0;
    do_reset();
    shadow_we = 1'h1;
    for (int i = 0; i < 4; i++) begin
      shadow_idx = i[1:0];
      shadow_data = SH[i];
      step(1);
    end
    shadow_we = 1'h0;
    foreach (ROWS[i]) begin
      rank_sel = ROWS[i].rank;
      strobe_in = ROWS[i].stb;
      postamble_en = ROWS[i].pam;
      step(1);
      chk(chain_setting, ROWS[i].exp_chain);
      step(2);
      chk(strobe_gated, ROWS[i].exp_gate);
      chk(fifo_wr_en, ROWS[i].exp_gate);
    end
    $display("test rows done");
    rank_sel = 2'h1;
    cal_start = 1'h1;
    step(1);
    cal_start = 1'h0;
    step(1);
    chk(busy, 9'h001);
    step(20);
    cal_start = 1'h1;
    step(1);
    cal_start = 1'h0;
    step(2);
    chk(busy, 9'h001);
    for (int n = 0; n < 400 && dll_locked !== 1'h1; n++) step(1);
    chk(dll_locked, 9'h001);
    step(3);
    chk(near(dll_setting, target), 9'h001);
    chk(near(chain_setting - SH[1], target - 9'h100), 9'h001);
    target = 9'h0F4;
    step(80);
    chk(near(dll_setting, target), 9'h001);
    chk(near(chain_setting - SH[1], target - 9'h100), 9'h001);
    cal_start = 1'h1;
    step(1);
    cal_start = 1'h0;
    step(2);
    chk(dll_locked, 9'h000);
    chk(busy, 9'h001);
    for (int n = 0; n < 400 && dll_locked !== 1'h1; n++) step(1);
    chk(dll_locked, 9'h001);
    step(3);
    chk(near(dll_setting, target), 9'h001);
    $display("test calibration done");
    do_reset();
    complete_run();
  end
endmodule
